// ---- design/spm_bit_pick.sv ----
// spm_bit_pick: combinational selection of one status bit for one pin
// assumes status bytes of all applications arrive flattened on one bus
module spm_bit_pick #(
   parameter int unsigned APPS = 32,
   parameter int unsigned BITS = 256
) (
   input wire logic [APPS*BITS-1:0] status_flat, // all status bits, app-major
   input wire spm_pkg::spm_pin_cfg_t cfg, // mapping of this pin
   output logic level // level to drive on the pin
);
   logic sel_bit;
   logic assigned;
   // pick bit counted across the app's bytes, then apply polarity
   always_comb begin
      assigned = (cfg.application_index != spm_pkg::APP_NONE) &&
                 (cfg.application_index < 8'(APPS));
      sel_bit = 1'b0;
      if (assigned) begin
         sel_bit = status_flat[cfg.application_index[4:0] * BITS +
                               cfg.status_bit_index];
      end
      level = sel_bit ^ cfg.pol;
   end
endmodule

// ---- design/spm_pkg.sv ----
// spm_pkg: register map, reset values and shared types for the pin status mapper
// assumes a byte-wide register port and a scheduler that pulses task runs
package spm_pkg;
   localparam int unsigned NUM_PINS = 4;
   localparam int unsigned NUM_APPS = 32;
   localparam int unsigned STATUS_BITS = 256;
   // register offsets
   localparam logic [7:0] OFF_PIN_A_APP = 8'h00;
   localparam logic [7:0] OFF_PIN_A_BIT = 8'h01;
   localparam logic [7:0] OFF_POL_HIGH = 8'h08;
   localparam logic [7:0] OFF_POL_LOW = 8'h09;
   localparam logic [7:0] OFF_SCHED = 8'h0a;
   localparam logic [7:0] REG_COUNT = 8'h0a;
   // reset values
   localparam logic [7:0] APP_RESET = 8'hff;
   localparam logic [7:0] APP_NONE = 8'hff;
   localparam logic [7:0] BIT_RESET = 8'h00;
   localparam logic [7:0] POL_RESET = 8'h00;
   localparam logic [7:0] SCHED_RESET = 8'hd7;
   // polarity field positions: high byte holds d (bit1) and c (bit0)
   localparam int unsigned POL_HI_D = 1;
   localparam int unsigned POL_HI_C = 0;
   localparam int unsigned POL_LO_B = 7;
   localparam int unsigned POL_LO_A = 6;
   // scheduler field
   localparam int unsigned ACT_MSB = 7;
   localparam int unsigned ACT_LSB = 6;
   localparam logic [5:0] TOP_RATE_TASK_LEVEL = 6'h17;
   typedef enum logic [1:0] {
      SPM_ACT_NEVER = 2'h0,
      SPM_ACT_LOW = 2'h1,
      SPM_ACT_HIGH = 2'h2,
      SPM_ACT_ALWAYS = 2'h3
   } spm_activity_t;
   // register write/read request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } spm_req_t;
   // per-pin mapping
   typedef struct packed {
      logic [7:0] application_index;
      logic [7:0] status_bit_index;
      logic pol;
   } spm_pin_cfg_t;
endpackage

// ---- design/spm_top.sv ----
// spm_top: maps chosen application status bits onto four output pins
// assumes a byte register port and a task tick pulse from the scheduler
module spm_top #(
   parameter int unsigned APPS = spm_pkg::NUM_APPS,
   parameter int unsigned BITS = spm_pkg::STATUS_BITS
) (
   input wire logic clk, // 125 mhz clock
   input wire logic rst, // synchronous reset, active high
   input wire spm_pkg::spm_req_t req, // register access request
   output logic [7:0] rdata_q, // read data, valid cycle after rd
   output logic rvalid_q, // read data strobe
   input wire logic [APPS*BITS-1:0] status_flat, // application status bits
   input wire logic task_tick, // scheduler interval pulse
   input wire logic act_high, // motion activity is high
   output logic [5:0] task_level_q, // priority presented to scheduler
   output logic task_ran_q, // pulse when mapping task executed
   output logic [3:0] pin_output_level_q // pins a..d at bits 0..3
);
   logic [7:0] app_q [spm_pkg::NUM_PINS];
   logic [7:0] bit_q [spm_pkg::NUM_PINS];
   logic [1:0] pol_hi_q;
   logic [1:0] pol_lo_q;
   logic [7:0] sched_q;
   logic [3:0] pol;
   logic [3:0] level;
   logic run;
   // write strobes and next values
   logic [spm_pkg::NUM_PINS-1:0] wr_app; // per-pin app select write
   logic [spm_pkg::NUM_PINS-1:0] wr_bit; // per-pin bit select write
   logic wr_pol_hi; // high polarity byte write
   logic wr_pol_lo; // low polarity byte write
   logic wr_sched; // scheduler byte write
   logic [1:0] pol_hi_d; // polarity fields of a high byte write
   logic [1:0] pol_lo_d; // polarity fields of a low byte write
   logic [3:0] pin_output_level_d; // pin levels for the next cycle
   logic [7:0] rdata_d; // read multiplexer result
   spm_pkg::spm_activity_t activity; // activity field of the scheduler byte
   // polarity vector in pin order a,b,c,d
   assign pol = {pol_hi_q[1], pol_hi_q[0], pol_lo_q[1], pol_lo_q[0]};

   // select registers, two per pin
   genvar gi;
   generate
      for (gi = 0; gi < spm_pkg::NUM_PINS; gi++) begin : g_pin
         localparam logic [7:0] A_OFF = spm_pkg::OFF_PIN_A_APP + 8'(2 * gi);
         localparam logic [7:0] B_OFF = spm_pkg::OFF_PIN_A_BIT + 8'(2 * gi);
         spm_pkg::spm_pin_cfg_t cfg;
         // strobes for this pin's two select bytes
         assign wr_app[gi] = req.wr && (req.addr == A_OFF);
         assign wr_bit[gi] = req.wr && (req.addr == B_OFF);
         // application select, resets to unassigned
         always_ff @(posedge clk) begin
            if (rst) begin
               app_q[gi] <= spm_pkg::APP_RESET;
            end else if (wr_app[gi]) begin
               app_q[gi] <= req.wdata;
            end
         end
         // status bit select
         always_ff @(posedge clk) begin
            if (rst) begin
               bit_q[gi] <= spm_pkg::BIT_RESET;
            end else if (wr_bit[gi]) begin
               bit_q[gi] <= req.wdata;
            end
         end
         assign cfg = '{application_index: app_q[gi], status_bit_index: bit_q[gi],
                        pol: pol[gi]};
         spm_bit_pick #(.APPS(APPS), .BITS(BITS)) u_pick (
            .status_flat(status_flat),
            .cfg(cfg),
            .level(level[gi])
         );
      end
   endgenerate

   // write strobes for polarity and scheduler bytes
   always_comb begin
      wr_pol_hi = 1'b0;
      wr_pol_lo = 1'b0;
      wr_sched = 1'b0;
      if (req.wr) begin
         if (req.addr == spm_pkg::OFF_POL_HIGH) begin
            wr_pol_hi = 1'b1;
         end else if (req.addr == spm_pkg::OFF_POL_LOW) begin
            wr_pol_lo = 1'b1;
         end else if (req.addr == spm_pkg::OFF_SCHED) begin
            wr_sched = 1'b1;
         end
      end
   end

   // polarity fields pulled from the written byte; bit 1 of each pair is the later pin
   always_comb begin
      pol_hi_d = {req.wdata[spm_pkg::POL_HI_D], req.wdata[spm_pkg::POL_HI_C]};
      pol_lo_d = {req.wdata[spm_pkg::POL_LO_B], req.wdata[spm_pkg::POL_LO_A]};
   end

   // high polarity byte: pins d and c
   always_ff @(posedge clk) begin
      if (rst) begin
         pol_hi_q <= spm_pkg::POL_RESET[1:0];
      end else if (wr_pol_hi) begin
         pol_hi_q <= pol_hi_d;
      end
   end

   // low polarity byte: pins b and a, other bits reserved
   always_ff @(posedge clk) begin
      if (rst) begin
         pol_lo_q <= spm_pkg::POL_RESET[1:0];
      end else if (wr_pol_lo) begin
         pol_lo_q <= pol_lo_d;
      end
   end

   // scheduler parameters: activity and priority
   always_ff @(posedge clk) begin
      if (rst) begin
         sched_q <= spm_pkg::SCHED_RESET;
      end else if (wr_sched) begin
         sched_q <= req.wdata;
      end
   end

   // activity field of the scheduler byte
   assign activity = spm_pkg::spm_activity_t'(sched_q[spm_pkg::ACT_MSB:spm_pkg::ACT_LSB]);

   // activity gating of the task
   always_comb begin
      case (activity)
         spm_pkg::SPM_ACT_ALWAYS: run = task_tick;
         spm_pkg::SPM_ACT_HIGH: run = task_tick & act_high;
         spm_pkg::SPM_ACT_LOW: run = task_tick & ~act_high;
         default: run = 1'b0;
      endcase
   end

   // next pin levels: fresh levels on a run, hold otherwise
   always_comb begin
      pin_output_level_d = pin_output_level_q;
      if (run) begin
         pin_output_level_d = level;
      end
   end

   // pin levels, held between task runs
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_output_level_q <= 4'h0;
      end else begin
         pin_output_level_q <= pin_output_level_d;
      end
   end

   // one-cycle marker of an executed task run
   always_ff @(posedge clk) begin
      if (rst) begin
         task_ran_q <= 1'b0;
      end else begin
         task_ran_q <= run;
      end
   end

   // priority presented to the scheduler
   always_ff @(posedge clk) begin
      if (rst) begin
         task_level_q <= spm_pkg::TOP_RATE_TASK_LEVEL;
      end else begin
         task_level_q <= sched_q[5:0];
      end
   end

   // read multiplexer; reserved bits and unmapped offsets read zero
   always_comb begin
      rdata_d = 8'h00;
      if (req.addr < spm_pkg::OFF_POL_HIGH) begin
         if (req.addr[0]) begin
            rdata_d = bit_q[req.addr[2:1]];
         end else begin
            rdata_d = app_q[req.addr[2:1]];
         end
      end else if (req.addr == spm_pkg::OFF_POL_HIGH) begin
         rdata_d = {6'h00, pol_hi_q[1], pol_hi_q[0]};
      end else if (req.addr == spm_pkg::OFF_POL_LOW) begin
         rdata_d = {pol_lo_q[1], pol_lo_q[0], 6'h00};
      end else if (req.addr == spm_pkg::OFF_SCHED) begin
         rdata_d = sched_q;
      end
   end

   // read strobe, answered one cycle later
   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= req.rd;
      end
   end

   // read data, zero outside a read answer
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (req.rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end
endmodule

// ---- sim/spm_pin_sampler.sv ----
// spm_pin_sampler: outside circuit latching the pins
// assumes task_ran_q marks settled pin levels
module spm_pin_sampler (
   input wire logic clk, // clock
   input wire logic ran, // run pulse
   input wire logic [3:0] pins, // pin levels
   output logic [3:0] seen_q // last sample
);
   timeunit 1ns;
   timeprecision 100ps;
   // latch pins after each run
   always_ff @(posedge clk) begin
      if (ran)
         seen_q <= pins;
   end
endmodule

// ---- sim/spm_top_properties.sv ----
// spm_top_properties: port checks of the pin status mapper
// assumes binding into spm_top, one clock, sync reset
module spm_top_properties (
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire spm_pkg::spm_req_t req, // request
   input wire logic [7:0] rdata_q, // read data
   input wire logic rvalid_q, // read strobe
   input wire logic task_tick, // tick
   input wire logic task_ran_q, // run pulse
   input wire logic [5:0] task_level_q, // priority
   input wire logic [3:0] pin_output_level_q // pins
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic cfg_q; // mapping written since reset
   // note any write to the mapping bytes
   always_ff @(posedge clk) begin
      if (rst)
         cfg_q <= 1'b0;
      else if (req.wr && req.addr < 8'h0a)
         cfg_q <= 1'b1;
   end
   property p_rd; req.rd |=> rvalid_q; endproperty
   a_rd: assert property (p_rd) else $error("read unanswered");
   property p_idle; !rvalid_q |-> rdata_q == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("stray data");
   property p_gap; rvalid_q && $past(req.addr) > 8'h0a |-> rdata_q == 8'h00; endproperty
   a_gap: assert property (p_gap) else $error("unmapped read");
   property p_resv; rvalid_q && $past(req.addr) == 8'h09 |-> rdata_q[5:0] == 6'h00; endproperty
   a_resv: assert property (p_resv) else $error("reserved bits set");
   property p_ran; task_ran_q |-> $past(task_tick); endproperty
   a_ran: assert property (p_ran) else $error("run without tick");
   property p_hold; !task_ran_q |-> $stable(pin_output_level_q); endproperty
   a_hold: assert property (p_hold) else $error("pins moved");
   property p_lvl; !$past(req.wr, 2) |-> $stable(task_level_q); endproperty
   a_lvl: assert property (p_lvl) else $error("priority moved");
   property p_unset; !cfg_q |-> pin_output_level_q == 4'h0; endproperty
   a_unset: assert property (p_unset) else $error("pin set unmapped");
endmodule
bind spm_top spm_top_properties u_props (.clk(clk), .rst(rst), .req(req),
   .rdata_q(rdata_q), .rvalid_q(rvalid_q), .task_tick(task_tick), .task_ran_q(task_ran_q),
   .task_level_q(task_level_q), .pin_output_level_q(pin_output_level_q));

// ---- sim/test_spm_top.sv ----
// test_spm_top: self-checking bench of the pin status mapper
// assumes spm_top, its checker and the pin sampler are compiled
module test_spm_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, tick, act, rv, ran;
   spm_pkg::spm_req_t req;
   logic [7:0] rdat;
   logic [5:0] lvl;
   logic [3:0] pins, seen;
   logic [8191:0] st;
   int err_total = 0, num_checks = 0, cyc = 0;
   spm_top dut (.clk(clk), .rst(rst), .req(req), .rdata_q(rdat), .rvalid_q(rv),
      .status_flat(st), .task_tick(tick), .act_high(act), .task_level_q(lvl),
      .task_ran_q(ran), .pin_output_level_q(pins));
   spm_pin_sampler u_far (.clk(clk), .ran(ran), .pins(pins), .seen_q(seen));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic ck(input logic [7:0] g, e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk) req <= {1'b1, 1'b0, a, d};
      @(posedge clk) req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge clk) req <= {1'b0, 1'b1, a, 8'h00};
      @(posedge clk) req <= '0;
      @(negedge clk) ck(rv, 8'h01);
      ck(rdat, e);
   endtask
   task automatic tk(input logic r, input logic [3:0] p);
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
      @(negedge clk) ck(ran, r);
      ck(pins, p);
   endtask
   // reset values, unmapped place, idle pins
   task automatic t_reset();
      for (int a = 0; a < 11; a++)
         rd(a[7:0], a == 10 ? 8'hd7 : (a < 8 && a % 2 == 0) ? 8'hff : 8'h00);
      ck(lvl, 8'h17);
      wr(8'h0b, 8'h5a);
      rd(8'h0b, 8'h00);
      tk(1'b1, 4'h0);
   endtask
   // bit 200 of app 3, then both polarity bytes
   task automatic t_map();
      wr(8'h00, 8'h03);
      wr(8'h01, 8'hc8);
      st[968] <= 1'b1;
      tk(1'b1, 4'h1);
      wr(8'h09, 8'h40);
      tk(1'b1, 4'h0);
      wr(8'h09, 8'h80);
      wr(8'h08, 8'h02);
      tk(1'b1, 4'hb);
      rd(8'h09, 8'h80);
      ck(seen, 8'h0b);
   endtask
   // every activity code at low and high activity
   task automatic t_act();
      logic r;
      logic [3:0] p;
      p = 4'hb;
      for (int m = 0; m < 8; m++) begin
         r = (m / 2 == 3) || (m / 2 == 2 && m[0]) || (m / 2 == 1 && !m[0]);
         wr(8'h0a, {m[2:1], 6'h17});
         act <= m[0];
         st[968] <= ~st[968];
         if (r)
            p = p ^ 4'h1;
         tk(r, p);
      end
      wr(8'h0a, 8'hc5);
      rd(8'h0a, 8'hc5);
      ck(lvl, 8'h05);
   endtask
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", err_total, num_checks);
      if (err_total == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      req = '0;
      tick = 1'b0;
      act = 1'b0;
      st = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_map();
      t_act();
      tally_and_finish();
   end
endmodule
